// file: src/cct_pkg.sv
// Package for the capture/compare timer: register map, fields, reset values.
// Assumes a 32-bit Avalon-MM slave addressed directly with the byte offsets below.
package cct_pkg;
    // Register byte offsets
    localparam logic [7:0] CCT_OFF_CTRL_ONE = 8'h00; // Run enable
    localparam logic [7:0] CCT_OFF_CTRL_TWO = 8'h04; // Prescale select
    localparam logic [7:0] CCT_OFF_ROLE = 8'h08; // Channel role select
    localparam logic [7:0] CCT_OFF_IRQ_EN = 8'h0C; // Channel interrupt enable (mask)
    localparam logic [7:0] CCT_OFF_FLAGS = 8'h10; // Sticky event flags, write one to clear
    localparam logic [7:0] CCT_OFF_COUNT = 8'h14; // Timer counter, read only
    localparam logic [7:0] CCT_OFF_ACCUM = 8'h18; // Pulse accumulator, write clears
    localparam logic [7:0] CCT_OFF_EDGE = 8'h1C; // Edge select, two bits per channel
    localparam logic [7:0] CCT_OFF_ACTION = 8'h20; // Compare action, two bits per channel
    localparam logic [7:0] CCT_OFF_PINS = 8'h24; // Output pin state, read only
    localparam logic [7:0] CCT_OFF_CHAN = 8'h40; // Per-channel value base, stride 4
    // Field positions
    localparam int CCT_RUN_BIT = 0;
    localparam int CCT_PRESCALE_W = 3;
    // Reset values
    localparam logic [15:0] CCT_COUNT_RST = 16'h0000;
    localparam logic [7:0] CCT_BYTE_RST = 8'h00;
    localparam logic [15:0] CCT_WORD_RST = 16'h0000;
    // Edge select codes
    typedef enum logic [1:0] {
        CCT_EDGE_OFF = 2'h0,
        CCT_EDGE_RISE = 2'h1,
        CCT_EDGE_FALL = 2'h2,
        CCT_EDGE_ANY = 2'h3
    } cct_edge_e;
    // Compare action codes
    typedef enum logic [1:0] {
        CCT_ACT_IRQ = 2'h0,
        CCT_ACT_TOGGLE = 2'h1,
        CCT_ACT_LOW = 2'h2,
        CCT_ACT_HIGH = 2'h3
    } cct_action_e;
endpackage : cct_pkg

// file: src/cct_prescaler.sv
// Prescaler: divides the module clock by 2**prescaleSelect into a tick pulse.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ns
module cct_prescaler
    import cct_pkg::*;
#(
    parameter int PW = CCT_PRESCALE_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [PW-1:0] prescaleSelect,
    output logic tick
);
    localparam int DW = (1 << PW) - 1;
    logic [DW-1:0] divCount; // Free divider, held while stopped
    wire logic [DW-1:0] divMask = DW'((1 << prescaleSelect) - 1);

    // Tick when the low bits of the divider all reach one
    assign tick = run && ((divCount & divMask) == divMask);

    // Divider advances only while running
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            divCount <= '0;
        end else if (run) begin
            divCount <= divCount + DW'(1);
        end
    end
endmodule : cct_prescaler

// file: src/cct_channel.sv
// One timer channel: input capture or output compare on one pin.
// Assumes pinIn is already synchronised and tick/count share the clock.
`timescale 1ns/1ns
module cct_channel
    import cct_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pinIn,
    input wire logic roleOut,
    input wire logic [1:0] edgeSel,
    input wire logic [1:0] actionSel,
    input wire logic tick,
    input wire logic [15:0] count,
    input wire logic [15:0] compareValue,
    output logic [15:0] captured,
    output logic pinOut,
    output logic event_
);
    logic pinPrev; // Previous synchronised level
    wire logic rise = pinIn && !pinPrev;
    wire logic fall = !pinIn && pinPrev;
    wire logic edgeHit = (edgeSel == CCT_EDGE_RISE && rise) ||
        (edgeSel == CCT_EDGE_FALL && fall) || (edgeSel == CCT_EDGE_ANY && (rise || fall));
    wire logic captureHit = !roleOut && edgeHit;
    // Compare only on a tick so each match fires once per count value
    wire logic matchHit = roleOut && tick && (count == compareValue);
    logic next_pinOut;

    // Output action on match
    always_comb begin
        next_pinOut = pinOut;
        if (matchHit) begin
            unique case (actionSel)
                CCT_ACT_IRQ: next_pinOut = pinOut;
                CCT_ACT_TOGGLE: next_pinOut = !pinOut;
                CCT_ACT_LOW: next_pinOut = 1'b0;
                CCT_ACT_HIGH: next_pinOut = 1'b1;
            endcase
        end
    end

    assign event_ = captureHit || matchHit;

    // Latch counter on capture, pin state on compare
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinPrev <= 1'b0;
            captured <= CCT_WORD_RST;
            pinOut <= 1'b0;
        end else begin
            pinPrev <= pinIn;
            if (captureHit) captured <= count;
            pinOut <= next_pinOut;
        end
    end

    a_capture_latches: assert property (@(posedge clock) disable iff (!rst_n)
        captureHit |=> captured == $past(count))
        else $error("capture value wrong");
endmodule : cct_channel

// file: src/cct_timer.sv
// Capture/compare timer top: Avalon-MM slave, counter, eight channels, accumulator.
// Assumes a single 20 MHz clock; capture pins are asynchronous to it.
// Register map and field codes come from the shared package.
//
// Function
// - 16-bit counter rate set by software prescaler
// - Eight channels, each capture or compare
// - Role bit: 0 capture, 1 compare
// - Capture latches counter on input event
// - Capture edge: rising, falling or either
// - Channel 7 accumulator counts input events
// - Compare detects counter equal to value
// - Compare action: irq, toggle, low, high
// - Interrupt enable register gates channel requests
// - Counter stopped until run enable set
`timescale 1ns/1ns
module cct_timer
    import cct_pkg::*;
#(
    parameter int NCH = 8 // Channel count
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NCH-1:0] captureIn,
    output logic [NCH-1:0] compareOut,
    output logic irq
);
    // Software-visible state
    logic timerRunEnable; // Global run bit
    logic [CCT_PRESCALE_W-1:0] prescaleSelect; // Divider exponent
    logic [NCH-1:0] channelRoleSelect; // 1 = compare
    logic [NCH-1:0] channelIrqEnable; // Interrupt mask
    logic [NCH-1:0] eventFlags; // Sticky flags
    logic [2*NCH-1:0] edgeSelect; // Two bits each
    logic [2*NCH-1:0] actionSelect; // Two bits each
    logic [15:0] compareValue [NCH]; // Compare registers
    logic [15:0] count; // Timer counter
    logic [15:0] accum; // Pulse accumulator
    logic readAck; // One-cycle read wait

    // Pin synchronisers: three stages, change counted when stages two and three agree
    logic [NCH-1:0] syncA;
    logic [NCH-1:0] syncB;
    logic [NCH-1:0] syncC;
    logic [NCH-1:0] pinStable; // Filtered level

    // Per-channel results
    // Captured words are read back through the channel window, never written
    logic [15:0] captured [NCH];
    logic [NCH-1:0] chanEvent;
    logic tick;

    // Address decode. Byte-wide control registers need lane zero, so a write
    // with lane zero off leaves them alone; the edge and action words are
    // sixteen bits wide and take any lane pattern.
    wire logic wr = avs_write && avs_byteenable[0];
    wire logic wrCtrlOne = wr && avs_address == CCT_OFF_CTRL_ONE;
    wire logic wrCtrlTwo = wr && avs_address == CCT_OFF_CTRL_TWO;
    wire logic wrRole = wr && avs_address == CCT_OFF_ROLE;
    wire logic wrIrqEn = wr && avs_address == CCT_OFF_IRQ_EN;
    wire logic wrFlags = wr && avs_address == CCT_OFF_FLAGS;
    wire logic wrAccum = wr && avs_address == CCT_OFF_ACCUM;
    wire logic wrEdge = avs_write && avs_address == CCT_OFF_EDGE;
    wire logic wrAction = avs_write && avs_address == CCT_OFF_ACTION;
    wire logic chanSpace = avs_address >= CCT_OFF_CHAN &&
        avs_address < CCT_OFF_CHAN + 8'(4 * NCH);
    wire logic [7:0] chanOff = avs_address - CCT_OFF_CHAN;
    wire logic [2:0] chanIdx = chanOff[4:2];
    wire logic [NCH-1:0] flagClear = wrFlags ? avs_writedata[NCH-1:0] : '0;
    wire logic accumEvent = !channelRoleSelect[NCH-1] && chanEvent[NCH-1];

    // Reads complete with one wait cycle so readdata stands at the taking edge
    // Writes never wait: every register takes its data on the first edge
    assign avs_waitrequest = avs_read && !readAck;

    // Read mux; unmapped addresses read zero
    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = '0;
        unique case (avs_address)
            CCT_OFF_CTRL_ONE: next_readdata[CCT_RUN_BIT] = timerRunEnable;
            CCT_OFF_CTRL_TWO: next_readdata[CCT_PRESCALE_W-1:0] = prescaleSelect;
            CCT_OFF_ROLE: next_readdata[NCH-1:0] = channelRoleSelect;
            CCT_OFF_IRQ_EN: next_readdata[NCH-1:0] = channelIrqEnable;
            CCT_OFF_FLAGS: next_readdata[NCH-1:0] = eventFlags;
            CCT_OFF_COUNT: next_readdata[15:0] = count;
            CCT_OFF_ACCUM: next_readdata[15:0] = accum;
            CCT_OFF_EDGE: next_readdata[2*NCH-1:0] = edgeSelect;
            CCT_OFF_ACTION: next_readdata[2*NCH-1:0] = actionSelect;
            CCT_OFF_PINS: next_readdata[NCH-1:0] = compareOut;
            default: begin
                // Channel word: capture in low half, compare in high half
                if (chanSpace) begin
                    next_readdata = {compareValue[chanIdx], captured[chanIdx]};
                end
            end
        endcase
    end

    // Read handshake and data register
    // readAck lasts one cycle, so a read held longer starts a new access
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readAck <= 1'b0;
            avs_readdata <= '0;
        end else begin
            readAck <= avs_read && !readAck;
            avs_readdata <= next_readdata;
        end
    end

    // Control registers
    // Setup order is left to software; any register may be written at any time
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timerRunEnable <= 1'b0;
            prescaleSelect <= '0;
            channelRoleSelect <= CCT_BYTE_RST;
            channelIrqEnable <= CCT_BYTE_RST;
            edgeSelect <= '0;
            actionSelect <= '0;
        end else begin
            if (wrCtrlOne) timerRunEnable <= avs_writedata[CCT_RUN_BIT];
            if (wrCtrlTwo) prescaleSelect <= avs_writedata[CCT_PRESCALE_W-1:0];
            if (wrRole) channelRoleSelect <= avs_writedata[NCH-1:0];
            if (wrIrqEn) channelIrqEnable <= avs_writedata[NCH-1:0];
            if (wrEdge) edgeSelect <= avs_writedata[2*NCH-1:0];
            if (wrAction) actionSelect <= avs_writedata[2*NCH-1:0];
        end
    end

    // Compare value registers, high half of the channel word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) compareValue[i] <= CCT_WORD_RST;
        end else if (avs_write && chanSpace && avs_byteenable[2]) begin
            compareValue[chanIdx] <= avs_writedata[31:16];
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    // Software clears with a one per bit, so other flags are left untouched
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eventFlags <= CCT_BYTE_RST;
        end else begin
            eventFlags <= (eventFlags & ~flagClear) | chanEvent;
        end
    end

    // Level interrupt: high while any enabled flag stands
    assign irq = |(eventFlags & channelIrqEnable);

    // Timer counter: stopped until run, wraps naturally at the top
    // The tick already carries the run bit, so no separate enable is needed
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= CCT_COUNT_RST;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // Pulse accumulator on channel 7; a software write clears it
    // A clear that meets an event loses; software reads back to confirm
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            accum <= CCT_WORD_RST;
        end else if (accumEvent) begin
            accum <= accum + 16'h0001;
        end else if (wrAccum) begin
            accum <= CCT_WORD_RST;
        end
    end

    // Synchroniser chain; first stage feeds only the second
    // Trade-off: the agreement stage costs a clock but rejects one-clock glitches
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            pinStable <= '0;
        end else begin
            syncA <= captureIn;
            syncB <= syncA;
            syncC <= syncB;
            pinStable <= (syncB & syncC) | (pinStable & (syncB | syncC));
        end
    end

    // Prescaler
    // The divider free-runs while enabled; a new prescale takes effect at once
    cct_prescaler #(.PW(CCT_PRESCALE_W)) u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .run(timerRunEnable),
        .prescaleSelect(prescaleSelect),
        .tick(tick)
    );

    // Eight identical channels
    // Each channel owns its edge detector, compare match and pin register
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        cct_channel u_chan (
            .clock(clock),
            .rst_n(rst_n),
            .pinIn(pinStable[c]),
            .roleOut(channelRoleSelect[c]),
            .edgeSel(edgeSelect[2*c+1:2*c]),
            .actionSel(actionSelect[2*c+1:2*c]),
            .tick(tick),
            .count(count),
            .compareValue(compareValue[c]),
            .captured(captured[c]),
            .pinOut(compareOut[c]),
            .event_(chanEvent[c])
        );
    end

    // Counter assertions: stopped, running, stepping and wrapping
    a_count_stopped: assert property (@(posedge clock) disable iff (!rst_n)
        !timerRunEnable |=> count == $past(count))
        else $error("counter moved while stopped");
    a_count_runs: assert property (@(posedge clock) disable iff (!rst_n)
        timerRunEnable && prescaleSelect == '0 |=> count != $past(count))
        else $error("counter idle while running undivided");
    a_count_wraps: assert property (@(posedge clock) disable iff (!rst_n)
        tick && count == 16'hFFFF |=> count == 16'h0000)
        else $error("counter did not wrap");
    a_count_steps: assert property (@(posedge clock) disable iff (!rst_n)
        tick |=> count == $past(count) + 16'h0001)
        else $error("counter step wrong");

    // Flag and interrupt assertions; an event in the cycle of a clear must win
    a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        chanEvent[0] |=> eventFlags[0])
        else $error("event flag not set");
    a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
        eventFlags[0] && !(wrFlags && avs_writedata[0]) |=> eventFlags[0])
        else $error("event flag dropped without a clear");
    a_flag_clears: assert property (@(posedge clock) disable iff (!rst_n)
        wrFlags && avs_writedata[0] && !chanEvent[0] |=> !eventFlags[0])
        else $error("event flag not cleared");
    a_irq_gated: assert property (@(posedge clock) disable iff (!rst_n)
        |(chanEvent & channelIrqEnable) && !wrIrqEn |=> irq)
        else $error("enabled event gave no irq");

    // Accumulator assertions
    a_accum_counts: assert property (@(posedge clock) disable iff (!rst_n)
        accumEvent |=> accum == $past(accum) + 16'h0001)
        else $error("accumulator missed event");
    a_accum_clear: assert property (@(posedge clock) disable iff (!rst_n)
        wrAccum && !accumEvent |=> accum == 16'h0000)
        else $error("accumulator not cleared");

    // Role assertions: role bits take the write, channel 0 in the compare role never captures
    a_role_write: assert property (@(posedge clock) disable iff (!rst_n)
        wrRole |=> channelRoleSelect == $past(avs_writedata[NCH-1:0]))
        else $error("role bits not written");
    a_role_capture: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[0] && $stable(channelRoleSelect) |=> $stable(captured[0]))
        else $error("compare channel captured");

    // Compare assertions on channel 1, one for each pin action; match flag on channel 2
    a_compare_high: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[1] && tick && count == compareValue[1] &&
        actionSelect[3:2] == CCT_ACT_HIGH |=> compareOut[1])
        else $error("compare set-high failed");
    a_compare_low: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[1] && tick && count == compareValue[1] &&
        actionSelect[3:2] == CCT_ACT_LOW |=> !compareOut[1])
        else $error("compare set-low failed");
    a_compare_toggle: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[1] && tick && count == compareValue[1] &&
        actionSelect[3:2] == CCT_ACT_TOGGLE |=> compareOut[1] != $past(compareOut[1]))
        else $error("compare toggle failed");
    a_compare_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[1] && tick && count == compareValue[1] &&
        actionSelect[3:2] == CCT_ACT_IRQ |=> $stable(compareOut[1]))
        else $error("interrupt-only compare moved the pin");
    a_compare_flag: assert property (@(posedge clock) disable iff (!rst_n)
        channelRoleSelect[2] && tick && count == compareValue[2] |=> eventFlags[2])
        else $error("compare match not flagged");

    // Bus assertions: writes never wait, reads wait one cycle only
    a_write_nowait: assert property (@(posedge clock) disable iff (!rst_n)
        avs_write |-> !avs_waitrequest)
        else $error("write was held off");
    a_read_wait: assert property (@(posedge clock) disable iff (!rst_n)
        avs_read && avs_waitrequest |=> !avs_waitrequest || !avs_read)
        else $error("read wait too long");
endmodule : cct_timer

// file: bench/cct_pin_model.sv
// Pin-side partner: drives capture waveforms and watches compare outputs.
// Assumes the bench calls drive_pin just after a rising clock edge.
`timescale 1ns/1ns
module cct_pin_model #(
    parameter int NCH = 8 // Pins on each side
) (
    input wire logic clock,
    output logic [NCH-1:0] captureIn,
    input wire logic [NCH-1:0] compareOut
);
    int outEdges = 0; // Compare pin changes seen so far
    logic [NCH-1:0] lastOut = '0; // Compare levels one clock ago

    // Pins idle low from time zero
    initial captureIn = '0;

    // Move one pin, then hold it long enough to pass the input filter
    task automatic drive_pin(input int ch, input logic lvl, input int hold);
        captureIn[ch] <= lvl;
        repeat (hold) @(posedge clock);
    endtask : drive_pin

    // Count compare pin changes, so a stray extra edge is noticed
    // Unknown levels before reset compare as no change, so reset adds no edges
    always @(posedge clock) begin
        if (compareOut != lastOut) outEdges <= outEdges + 1;
        lastOut <= compareOut;
    end
endmodule : cct_pin_model

// file: bench/tb.sv
// Self-checking bench for the capture/compare timer over Avalon-MM.
// Assumes the pin model on the far side and a 20 MHz clock.
`timescale 1ns/1ns
module tb;
    import cct_pkg::*;
    localparam logic [31:0] ZERO = 32'h0000_0000; // Common expected value
    logic clock; // 50 ns period
    logic rst_n = 1'h0; // Held low for five clocks
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = ZERO;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [7:0] captureIn;
    logic [7:0] compareOut;
    logic [31:0] rd; // Last read result
    logic [15:0] c1; // Count snapshots
    logic [15:0] c2;
    int failCount = 0;
    int numChecks = 0;
    logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0}; // High, low, toggle, irq only
    logic expPin [4] = '{1'h1, 1'h0, 1'h1, 1'h1}; // Pin level after each action

    cct_timer #(.NCH(8)) dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .captureIn(captureIn),
        .compareOut(compareOut), .irq(irq));
    cct_pin_model #(.NCH(8)) pins (.clock(clock), .captureIn(captureIn),
        .compareOut(compareOut));

    // Free-running clock
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    // Compare and count; four-state equality so X matches only X
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            failCount++;
        end
    endtask : check

    // Write; an idle clock follows so the strobe is never reassigned in one step
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'h1;
        @(posedge clock);
        while (avs_waitrequest !== 1'h0) @(posedge clock);
        avs_write <= 1'h0;
        @(posedge clock);
    endtask : bus_write

    // Read; data is taken at the edge that sees waitrequest low
    task automatic bus_read(input logic [7:0] a);
        avs_address <= a;
        avs_read <= 1'h1;
        @(posedge clock);
        while (avs_waitrequest !== 1'h0) @(posedge clock);
        rd = avs_readdata;
        avs_read <= 1'h0;
        @(posedge clock);
    endtask : bus_read

    task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus_read(a);
        check(what, rd, exp);
    endtask : rd_check

    // Single exit: counts, then verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Watchdog: the tests need about 66,100 clocks, most of them one counter lap
    initial begin
        repeat (80000) @(posedge clock);
        failCount++;
        give_verdict();
    end

    // Test sequence
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        rd_check("role reset", CCT_OFF_ROLE, ZERO);
        rd_check("unmapped", 8'h30, ZERO);
        check("irq idle", 32'(irq), ZERO);
        // Run enable without lane 0 must be ignored
        bus_write(CCT_OFF_CTRL_ONE, 32'h0000_0001, 4'h0);
        repeat (10) @(posedge clock);
        rd_check("count stopped", CCT_OFF_COUNT, ZERO);
        $display("test reset done");
        // Set up in the recommended order, then start
        bus_write(CCT_OFF_CTRL_TWO, 32'h0000_0002, 4'hF);
        bus_write(CCT_OFF_ROLE, 32'h0000_0002, 4'hF);
        bus_write(CCT_OFF_IRQ_EN, 32'h0000_0001, 4'hF);
        bus_write(CCT_OFF_CTRL_ONE, 32'h0000_0001, 4'hF);
        bus_read(CCT_OFF_COUNT);
        c1 = rd[15:0];
        repeat (40) @(posedge clock);
        bus_read(CCT_OFF_COUNT);
        c2 = rd[15:0] - c1;
        check("divide by four", 32'(c2 inside {16'h000A, 16'h000B}), 32'h0000_0001);
        // Divide by one: 11 clocks between the two samples
        bus_write(CCT_OFF_CTRL_TWO, ZERO, 4'hF);
        bus_read(CCT_OFF_COUNT);
        c1 = rd[15:0];
        repeat (8) @(posedge clock);
        bus_read(CCT_OFF_COUNT);
        check("divide by one", 32'(rd[15:0] - c1), 32'h0000_000B);
        // One full lap plus eleven: a counter that sticks at the top fails here
        bus_read(CCT_OFF_COUNT);
        c1 = rd[15:0];
        repeat (65544) @(posedge clock);
        bus_read(CCT_OFF_COUNT);
        c2 = rd[15:0] - c1;
        check("counter wrap", 32'(c2), 32'h0000_000B);
        $display("test counter done");
        // Each active edge code on channel 0 (rise, fall, any), rising then falling
        for (int code = 1; code < 4; code++) begin
            bus_write(CCT_OFF_EDGE, 32'(code), 4'hF);
            bus_write(CCT_OFF_FLAGS, 32'h0000_00FF, 4'hF);
            bus_read(CCT_OFF_COUNT);
            c1 = rd[15:0];
            pins.drive_pin(0, 1'h1, 10);
            bus_read(CCT_OFF_FLAGS);
            check("rise flag", 32'(rd[0]), 32'(code % 2));
            bus_read(CCT_OFF_CHAN);
            c2 = rd[15:0] - c1;
            if (code % 2 == 1) check("capture", 32'(c2 > 0 && c2 < 20), 32'h0000_0001);
            bus_write(CCT_OFF_FLAGS, 32'h0000_00FF, 4'hF);
            pins.drive_pin(0, 1'h0, 10);
            bus_read(CCT_OFF_FLAGS);
            check("fall flag", 32'(rd[0]), 32'(code / 2));
        end
        // Flag 0 still set from the last falling edge
        check("irq set", 32'(irq), 32'h0000_0001);
        bus_write(CCT_OFF_IRQ_EN, ZERO, 4'hF);
        check("irq masked", 32'(irq), ZERO);
        bus_write(CCT_OFF_IRQ_EN, 32'h0000_0001, 4'hF);
        check("irq unmasked", 32'(irq), 32'h0000_0001);
        bus_write(CCT_OFF_FLAGS, 32'h0000_0001, 4'hF);
        check("irq cleared", 32'(irq), ZERO);
        $display("test capture done");
        // Channel 7 on both edges: four edges counted
        bus_write(CCT_OFF_EDGE, 32'h0000_C000, 4'hF);
        bus_write(CCT_OFF_ACCUM, ZERO, 4'hF);
        for (int i = 0; i < 4; i++) pins.drive_pin(7, ~i[0], 10);
        rd_check("accumulator", CCT_OFF_ACCUM, 32'h0000_0004);
        // Channel 0 edge code is now off: a rise must leave its flag clear
        pins.drive_pin(0, 1'h1, 10);
        bus_read(CCT_OFF_FLAGS);
        check("edge off", 32'(rd[0]), ZERO);
        $display("test accumulator done");
        // Channel 1 compare, one action per pass
        for (int k = 0; k < 4; k++) begin
            bus_write(CCT_OFF_ACTION, 32'(acts[k]) << 2, 4'hF);
            bus_write(CCT_OFF_FLAGS, 32'h0000_00FF, 4'hF);
            bus_read(CCT_OFF_COUNT);
            bus_write(CCT_OFF_CHAN + 8'h04, {rd[15:0] + 16'h001E, 16'h0000}, 4'hF);
            repeat (50) @(posedge clock);
            check("compare pin", 32'(compareOut[1]), 32'(expPin[k]));
            rd_check("pin readback", CCT_OFF_PINS, 32'(expPin[k]) << 1);
            bus_read(CCT_OFF_FLAGS);
            check("compare flag", 32'(rd[1]), 32'h0000_0001);
        end
        check("pin edges", 32'(pins.outEdges), 32'h0000_0003);
        bus_write(CCT_OFF_ROLE, 32'h0000_00FF, 4'hF);
        rd_check("eight roles", CCT_OFF_ROLE, 32'h0000_00FF);
        $display("test compare done");
        give_verdict();
    end
endmodule : tb
